// File: hdl/dac_control_register_bank.sv
// Serial-access control and status registers of the converter
//
// What this block does
// - Status bit shows delay loop lock
// - Fixed revision and part identity fields read
// - Identity register top bit reads zero
// - Delay field delays samples one-four cycles
// - Self test enable bit starts core test
// - Signed read shift sets output pointer offset
// - Shift applied each alignment unless disabled
// - Format bit selects signed or offset binary
// - Delay and format registers reset 10, C0
`timescale 1ns/1ps
module dac_control_register_bank
  import dac_reg_pkg::*;
#(
  parameter logic [2:0] PART_ID  = 3'h5,  // Arbitrary value
  parameter logic [1:0] REG_REV  = 2'h0   // Arbitrary value
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                sclk,
  input  wire logic                sdenb_n,
  input  wire logic                sdio_in,
  output logic                     sdio_out,
  output logic                     sdio_oe,
  output logic                     sdo,
  input  wire logic                dll_lock,
  input  wire logic                sync_in,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output logic      [SAMPLE_W-1:0] sample_out,
  output logic      [PTR_W-1:0]    write_ptr,
  output logic      [PTR_W-1:0]    read_ptr,
  output logic                     core_selftest_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,  // Deselected
    SER_SHIFT = 2'b01,  // Taking or giving bits
    SER_DONE  = 2'b10   // Frame full, wait for deselect
  } ser_state_t;

  typedef struct packed {
    logic [15:0][7:0] regs;        // Register storage
    logic [2:0]       sclk_s;      // Bit 0 is first sync stage
    logic [2:0]       cs_s;        // Select sync, active low
    logic [1:0]       din_s;       // Serial data sync
    logic [1:0]       lock_s;      // Lock level sync
    logic [2:0]       sync_s;      // Alignment pin sync
    logic             sync_pulse;  // One cycle per alignment edge
    ser_state_t       state;       // Serial frame state
    logic [4:0]       bit_cnt;     // Bits taken this frame
    logic [7:0]       shift;       // Incoming shift register
    logic [7:0]       instr;       // Captured instruction byte
    logic [7:0]       rd_shift;    // Outgoing read data
    logic             sdio_out;    // Three-wire data out
    logic             sdio_oe;     // Three-wire drive enable
    logic             sdo;         // Four-wire data out
    logic             selftest;    // Self test run level
    logic             twos;        // Registered format select
  } bank_state_t;

  // Select sync starts deselected so reset is not followed by a false frame start
  localparam bank_state_t RESET_ST = '{regs:  RST_REGS,
                                       cs_s:  3'h7,
                                       state: SER_IDLE,
                                       twos:  1'b1,
                                       default: '0};

  bank_state_t st_reg;
  bank_state_t st_next;

  logic                rise;        // Serial clock rising
  logic                fall;        // Serial clock falling
  logic                selected;    // Frame in progress
  logic                four_wire;   // Read data leaves on sdo
  logic [7:0]          wr_data;     // Completed write byte
  logic [7:0]          id_word;     // Identity register value
  logic [SAMPLE_W-1:0] fmt_sample;  // Sample in signed form

  ////////////////////////////////////////////////////////////////////////////
  // Read view

  // Reserved registers read zero; lock comes from the synchroniser
  function automatic logic [7:0] read_value(input logic [3:0]       addr,
                                            input logic [15:0][7:0] regs,
                                            input logic [7:0]       idw);
    logic [7:0] v;
    v = regs[addr];
    if (addr == ADDR_ID_STATUS) begin
      v = idw;
    end else if (addr == ADDR_RESERVED_A || addr == ADDR_RESERVED_B ||
                 addr == ADDR_RESERVED_C) begin
      v = 8'h00;
    end
    return v;
  endfunction : read_value

  // Identity word: top bit zero, lock, unused zero, identity, revision
  assign id_word = {1'b0, st_reg.lock_s[1], 1'b0, PART_ID, REG_REV};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Serial slave: instruction byte then one data byte, MSB first.
  // Bits are taken on sclk rise and given on sclk fall.
  always_comb begin
    st_next        = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[1:0], sclk};
    st_next.cs_s   = {st_reg.cs_s[1:0], sdenb_n};
    st_next.din_s  = {st_reg.din_s[0], sdio_in};
    st_next.lock_s = {st_reg.lock_s[0], dll_lock};
    st_next.sync_s = {st_reg.sync_s[1:0], sync_in};
    // Alignment edge taken from the settled stages only
    st_next.sync_pulse = st_reg.sync_s[1] & ~st_reg.sync_s[2];
    st_next.selftest   = st_reg.regs[ADDR_DELAY_CFG][SELFTEST_BIT];
    st_next.twos       = st_reg.regs[ADDR_FORMAT_CFG][TWOS_BIT];

    rise      = st_reg.sclk_s[1] & ~st_reg.sclk_s[2];
    fall      = ~st_reg.sclk_s[1] & st_reg.sclk_s[2];
    selected  = ~st_reg.cs_s[1];
    four_wire = st_reg.regs[ADDR_IFACE_CFG][SIF4_BIT];
    wr_data   = {st_reg.shift[6:0], st_reg.din_s[1]};

    if (!selected) begin
      // Deselect aborts any frame and releases the data pin
      st_next.state    = SER_IDLE;
      st_next.bit_cnt  = '0;
      st_next.sdio_oe  = 1'b0;
      st_next.sdio_out = 1'b0;
      st_next.sdo      = 1'b0;
    end else begin
      unique case (st_reg.state)
        SER_IDLE, SER_SHIFT: begin
          st_next.state = SER_SHIFT;
          if (rise) begin
            st_next.shift   = wr_data;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            // Instruction complete: latch it and fetch read data
            if (st_reg.bit_cnt == INSTR_BITS - 5'h01) begin
              st_next.instr    = wr_data;
              st_next.rd_shift = read_value(wr_data[3:0], st_reg.regs, id_word);
            end
            // Data byte complete: store if writable
            if (st_reg.bit_cnt == XFER_BITS - 5'h01) begin
              st_next.state = SER_DONE;
              if (!st_reg.instr[INSTR_READ_BIT] &&
                  st_reg.instr[3:0] != ADDR_ID_STATUS &&
                  st_reg.instr[3:0] != ADDR_RESERVED_A &&
                  st_reg.instr[3:0] != ADDR_RESERVED_B &&
                  st_reg.instr[3:0] != ADDR_RESERVED_C) begin
                st_next.regs[st_reg.instr[3:0]] = wr_data;
              end
            end
          end else if (fall && st_reg.instr[INSTR_READ_BIT] &&
                       st_reg.bit_cnt >= INSTR_BITS) begin
            // Read data goes out one bit per falling edge
            st_next.rd_shift = {st_reg.rd_shift[6:0], 1'b0};
            if (four_wire) begin
              st_next.sdo     = st_reg.rd_shift[7];
              st_next.sdio_oe = 1'b0;
            end else begin
              st_next.sdio_out = st_reg.rd_shift[7];
              st_next.sdio_oe  = 1'b1;
            end
          end
        end
        SER_DONE: begin
          // Further clocks are ignored until deselect
          st_next.state = SER_DONE;
        end
        default: begin
          st_next.state = SER_IDLE;
        end
      endcase
    end
  end

  // State register; reset loads the documented defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  // Offset binary is turned to signed by flipping the sign bit
  assign fmt_sample = st_reg.twos ? sample_in :
                      {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]};

  // Output delay taken straight from the delay field
  sample_delay_line #(
    .WIDTH (SAMPLE_W)
  ) u_delay (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .delay_sel (st_reg.regs[ADDR_DELAY_CFG][DELAY_MSB:DELAY_LSB]),
    .din       (fmt_sample),
    .dout      (sample_out)
  );

  // Buffer pointers; realignment can be disabled from the interface register
  read_pointer_adjust u_ptr (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .align_pulse (st_reg.sync_pulse),
    .align_dis   (st_reg.regs[ADDR_IFACE_CFG][SYNC_DIS_BIT]),
    .rd_shift    (st_reg.regs[ADDR_DELAY_CFG][RSHIFT_MSB:0]),
    .wr_ptr      (write_ptr),
    .rd_ptr      (read_ptr)
  );

  assign sdio_out             = st_reg.sdio_out;
  assign sdio_oe              = st_reg.sdio_oe;
  assign sdo                  = st_reg.sdo;
  assign core_selftest_enable = st_reg.selftest;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_lock_follows: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst, 2) == 1'b0 |-> id_word[LOCK_BIT] == $past(dll_lock, 2))
    else $error("lock status does not follow the lock input");
  a_identity_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    id_word[4:0] == {PART_ID, REG_REV})
    else $error("identity fields changed");
  a_top_bit_zero: assert property (@(posedge clk) disable iff (sys_rst)
    id_word[7] == 1'b0 && id_word[5] == 1'b0)
    else $error("identity top bit not zero");
  a_selftest_level: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 core_selftest_enable == $past(st_reg.regs[ADDR_DELAY_CFG][SELFTEST_BIT]))
    else $error("self test enable does not follow its bit");
  a_format_offset: assert property (@(posedge clk) disable iff (sys_rst)
    !st_reg.twos |-> fmt_sample[SAMPLE_W-1] != sample_in[SAMPLE_W-1])
    else $error("offset binary sign not flipped");
  a_format_signed: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg.twos |-> fmt_sample == sample_in)
    else $error("signed input altered");
  a_reset_values: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> st_reg.regs[ADDR_DELAY_CFG] == 8'h10 &&
                       st_reg.regs[ADDR_FORMAT_CFG] == 8'hC0)
    else $error("configuration reset values wrong");
  a_id_not_written: assert property (@(posedge clk) disable iff (sys_rst)
    st_next.regs[ADDR_ID_STATUS] == st_reg.regs[ADDR_ID_STATUS])
    else $error("identity register storage written");

  c_write_frame: cover property (@(posedge clk) disable iff (sys_rst)
    st_reg.state == SER_DONE && !st_reg.instr[INSTR_READ_BIT]);
  c_read_frame: cover property (@(posedge clk) disable iff (sys_rst)
    st_reg.state == SER_DONE && st_reg.instr[INSTR_READ_BIT]);
  c_align_seen: cover property (@(posedge clk) disable iff (sys_rst)
    st_reg.sync_pulse);

endmodule : dac_control_register_bank

// File: hdl/dac_reg_pkg.sv
// Register map, field layout and reset values of the converter control bank
package dac_reg_pkg;

  // Register addresses
  localparam logic [3:0] ADDR_ID_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_DELAY_CFG    = 4'h1;
  localparam logic [3:0] ADDR_FORMAT_CFG   = 4'h2;
  localparam logic [3:0] ADDR_OFFSET_MASK  = 4'h3;
  localparam logic [3:0] ADDR_ERROR_FLAGS  = 4'h4;
  localparam logic [3:0] ADDR_IFACE_CFG    = 4'h5;
  localparam logic [3:0] ADDR_POWER_CFG    = 4'h6;
  localparam logic [3:0] ADDR_GAIN_CFG     = 4'h7;
  localparam logic [3:0] ADDR_LOOP_RESTART = 4'h8;
  localparam logic [3:0] ADDR_RESERVED_A   = 4'h9;
  localparam logic [3:0] ADDR_LOOP_TUNING  = 4'hA;
  localparam logic [3:0] ADDR_RESERVED_B   = 4'hB;
  localparam logic [3:0] ADDR_OFFSET_HIGH  = 4'hC;
  localparam logic [3:0] ADDR_OFFSET_LOW   = 4'hD;
  localparam logic [3:0] ADDR_SOUT_SELECT  = 4'hE;
  localparam logic [3:0] ADDR_RESERVED_C   = 4'hF;

  // Reset values, highest address first
  localparam logic [15:0][7:0] RST_REGS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h0C, 8'h00, 8'h00, 8'h70, 8'hC0, 8'h10, 8'h00};

  // Field positions
  localparam int LOCK_BIT      = 6;  // Identity register
  localparam int DELAY_MSB     = 7;  // Delay register
  localparam int DELAY_LSB     = 6;
  localparam int SELFTEST_BIT  = 3;
  localparam int RSHIFT_MSB    = 2;
  localparam int TWOS_BIT      = 7;  // Format register
  localparam int SIF4_BIT      = 7;  // Interface register
  localparam int SYNC_DIS_BIT  = 4;

  // Serial framing
  localparam int         INSTR_READ_BIT = 7;
  localparam logic [4:0] INSTR_BITS     = 5'h08;
  localparam logic [4:0] XFER_BITS      = 5'h10;

  // Data path widths
  localparam int SAMPLE_W = 16;
  localparam int PTR_W    = 3;

endpackage : dac_reg_pkg

// File: hdl/read_pointer_adjust.sv
// Input buffer pointers with read shift applied at each alignment pulse unless align_dis is set
`timescale 1ns/1ps
module read_pointer_adjust
  import dac_reg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             align_pulse,
  input  wire logic             align_dis,
  input  wire logic [2:0]       rd_shift,
  output logic      [PTR_W-1:0] wr_ptr,
  output logic      [PTR_W-1:0] rd_ptr
);

  typedef struct packed {
    logic [PTR_W-1:0] wr;  // Input pointer
    logic [PTR_W-1:0] rd;  // Output pointer
  } ptr_state_t;

  ptr_state_t st_reg;
  ptr_state_t st_next;

  // Both pointers walk once per sample; alignment reloads the read side
  always_comb begin
    st_next    = st_reg;
    st_next.wr = st_reg.wr + 3'h1;
    if (align_pulse && !align_dis) begin
      st_next.rd = st_next.wr + rd_shift;
    end else begin
      st_next.rd = st_reg.rd + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wr_ptr = st_reg.wr;
  assign rd_ptr = st_reg.rd;

  a_shift_applied: assert property (@(posedge clk) disable iff (sys_rst)
    align_pulse && !align_dis |=> rd_ptr == wr_ptr + $past(rd_shift))
    else $error("read shift not applied on alignment");
  a_shift_held: assert property (@(posedge clk) disable iff (sys_rst)
    align_pulse && align_dis |=> rd_ptr == $past(rd_ptr) + 3'h1)
    else $error("read pointer moved while alignment disabled");
  c_shift_minus4: cover property (@(posedge clk) disable iff (sys_rst)
    align_pulse && !align_dis && rd_shift == 3'h4);

endmodule : read_pointer_adjust

// File: hdl/sample_delay_line.sv
// Programmable one to four cycle delay on the converter sample path
`timescale 1ns/1ps
module sample_delay_line
  import dac_reg_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [1:0]       delay_sel,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [3:0][WIDTH-1:0] pipe;  // Tap 0 is one cycle old
    logic [WIDTH-1:0]      out;   // Registered selected tap
  } dly_state_t;

  dly_state_t st_reg;
  dly_state_t st_next;

  // Shift the taps and pick one; tap choice is combinational so a change
  // of the delay may repeat or skip up to three samples
  always_comb begin
    st_next         = st_reg;
    st_next.pipe[0] = din;
    for (int i = 1; i < 4; i++) begin
      st_next.pipe[i] = st_reg.pipe[i-1];
    end
    st_next.out = st_next.pipe[delay_sel];
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;

  a_delay_three: assert property (@(posedge clk) disable iff (sys_rst)
    (delay_sel == 2'h3) [*2] |-> dout == $past(din, 4))
    else $error("sample delay of three is wrong");
  a_delay_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(delay_sel) == 2'h0 |-> dout == $past(din))
    else $error("sample delay of zero is wrong");
  c_delay_max: cover property (@(posedge clk) disable iff (sys_rst)
    delay_sel == 2'h3 [*4]);

endmodule : sample_delay_line

// File: verification/tb.sv
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
module tb;
  import dac_reg_pkg::*;

  logic                clk;                   // 100 MHz system clock
  logic                sys_rst;               // Synchronous reset
  logic                sclk;                  // Serial clock pin
  logic                sdenb_n;               // Serial select, active low
  logic                sdio_in;               // Serial data into the bank
  logic                sdio_out;              // Three-wire read data
  logic                sdio_oe;               // Bank drives the data pin
  logic                sdo;                   // Four-wire read data
  logic                dll_lock;              // Delay loop lock level
  logic                sync_in;               // Alignment pin
  logic [SAMPLE_W-1:0] sample_in;             // Input sample
  logic [SAMPLE_W-1:0] sample_out;            // Delayed, formatted sample
  logic [PTR_W-1:0]    write_ptr;             // Buffer input pointer
  logic [PTR_W-1:0]    read_ptr;              // Buffer output pointer
  logic                core_selftest_enable;  // Self test enable level
  logic [7:0]          mdl [16];              // Register model
  logic [15:0]         hist [$];              // Samples driven so far
  int                  n_fail;                // Mismatch count
  int                  n_compared;            // Comparison count
  int unsigned         seed_val;              // Return of the seeding call

  localparam logic [2:0] PART_ID_TB = 3'h2;  // Arbitrary value
  localparam logic [1:0] REG_REV_TB = 2'h0;  // Arbitrary value

  dac_control_register_bank #(.PART_ID(PART_ID_TB), .REG_REV(REG_REV_TB)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .sdenb_n(sdenb_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo(sdo),
    .dll_lock(dll_lock), .sync_in(sync_in), .sample_in(sample_in),
    .sample_out(sample_out), .write_ptr(write_ptr), .read_ptr(read_ptr),
    .core_selftest_enable(core_selftest_enable));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about 22k cycles; allow over four times that
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // One comparison, four-state exact
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One serial frame; half periods of 8 clk leave room for the 2-flop syncs
  task automatic xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic four;
    four = mdl[5][SIF4_BIT];
    rd = 8'h00;
    sdenb_n = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      sdio_in = (i > 7) ? ins[i-8] : wd[i];
      tick(8);
      sclk = 1'b1;
      if (i < 8 && ins[INSTR_READ_BIT]) begin
        rd[i] = four ? sdo : sdio_out;
        if (!four && i == 0) begin
          chk("sdio_oe", 16'h1, {15'h0, sdio_oe});
          chk("sdo_idle", 16'h0, {15'h0, sdo});
        end
      end
      tick(8);
    end
    sclk = 1'b0;
    tick(4);
    sdenb_n = 1'b1;
    tick(10);
  endtask : xfer

  // Register write; reserved and status places keep their value
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    xfer({4'h0, a}, d, dummy);
    if (a != 4'h0 && a != 4'h9 && a != 4'hB && a != 4'hF) begin
      mdl[a] = d;
    end
  endtask : wr

  // Register read compared with the model
  task automatic rd_chk(input logic [3:0] a);
    logic [7:0] got;
    mdl[0] = {1'b0, dll_lock, 1'b0, PART_ID_TB, REG_REV_TB};
    xfer({4'h8, a}, 8'h00, got);
    chk($sformatf("reg_%0h", a), {8'h00, mdl[a]}, {8'h00, got});
  endtask : rd_chk

  // One alignment pulse, then the reload settles
  task automatic pulse_sync();
    sync_in = 1'b1;
    tick(4);
    sync_in = 1'b0;
    tick(10);
  endtask : pulse_sync

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0]  v8;
    logic [15:0] ws;
    logic [2:0]  code;
    logic [2:0]  w0;
    n_fail = 0;
    n_compared = 0;
    seed_val = $urandom(12);
    sys_rst = 1'b1;
    sclk = 1'b0;
    sdenb_n = 1'b1;
    sdio_in = 1'b0;
    dll_lock = 1'b1;
    sync_in = 1'b0;
    sample_in = 16'h0000;
    mdl = '{8'h00, 8'h10, 8'hC0, 8'h70, 8'h00, 8'h00, 8'h0C, 8'hFF,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    tick(3);
    sys_rst = 1'b0;
    tick(4);
    // Reset values, identity, lock shown and lost
    for (int a = 0; a < 16; a++) rd_chk(4'(a));
    dll_lock = 1'b0;
    tick(6);
    rd_chk(4'h0);
    dll_lock = 1'b1;
    // Random contents at addresses 1 to 15, reserved bits kept as required
    for (int a = 1; a < 16; a++) begin
      v8 = 8'($urandom);
      if (a == 1) v8[4] = 1'b1;
      if (a == 2) v8 = {v8[7], 1'b1, 1'b0, v8[4], 4'h0};
      wr(4'(a), v8);
    end
    for (int a = 0; a < 16; a++) rd_chk(4'(a));
    wr(4'h5, 8'h00);
    // Self test enable follows its bit
    wr(4'h1, 8'h18);
    chk("selftest_on", 16'h1, {15'h0, core_selftest_enable});
    wr(4'h1, 8'h10);
    chk("selftest_off", 16'h0, {15'h0, core_selftest_enable});
    // Every delay in both input formats
    for (int f = 0; f < 2; f++) begin
      for (int d = 0; d < 4; d++) begin
        wr(4'h1, {2'(d), 6'h10});
        wr(4'h2, {f[0], 7'h40});
        hist.delete();
        repeat (30) begin
          if (hist.size() > d + 5) begin
            ws = hist[hist.size() - 1 - d];
            chk("sample_out", f[0] ? ws : ws ^ 16'h8000, sample_out);
          end
          ws = 16'($urandom);
          sample_in = ws;
          hist.push_back(ws);
          tick(1);
        end
      end
    end
    // Pointer advance and every read shift code
    w0 = write_ptr;
    tick(1);
    chk("write_ptr", {13'h0, 3'(w0 + 3'h1)}, {13'h0, write_ptr});
    for (int s = 0; s < 8; s++) begin
      code = 3'(3 - s);
      wr(4'h1, {5'h02, code});
      pulse_sync();
      chk("ptr_gap", {13'h0, code}, {13'h0, 3'(read_ptr - write_ptr)});
    end
    // Realignment disabled: new shift is not applied
    wr(4'h5, 8'h10);
    wr(4'h1, 8'h12);
    pulse_sync();
    chk("ptr_hold", {13'h0, code}, {13'h0, 3'(read_ptr - write_ptr)});
    wr(4'h5, 8'h00);
    pulse_sync();
    chk("ptr_resume", 16'h2, {13'h0, 3'(read_ptr - write_ptr)});
    print_verdict();
  end

endmodule : tb
